// ---- rtl/sbu_consts.vh ----
// constants for the sbu path select decoder
`ifndef SBU_CONSTS_VH
`define SBU_CONSTS_VH
// strap level codes from the three-level resolver
`define SBU_LVL_LOW        2'h0
`define SBU_LVL_MID        2'h1
`define SBU_LVL_HIGH       2'h2
// path codes (select field value)
`define SBU_PATH_B         2'h0
`define SBU_PATH_AUDIO     2'h1
`define SBU_PATH_C         2'h2
`define SBU_PATH_A         2'h3
// one-hot switch bit positions
`define SBU_SW_B_STR       0
`define SBU_SW_B_SWP       1
`define SBU_SW_AUDIO       2
`define SBU_SW_C_STR       3
`define SBU_SW_A_STR       4
`define SBU_SW_A_SWP       5
`define SBU_SW_W           6
// timing, ns, at 25 MHz (40 ns period)
`define SBU_CLK_NS         40
`define SBU_DEB_NS         150
`define SBU_BBM_NS         1300
`define SBU_DEB_CYC        ((`SBU_DEB_NS + `SBU_CLK_NS - 1) / `SBU_CLK_NS)
`define SBU_BBM_CYC        ((`SBU_BBM_NS + `SBU_CLK_NS - 1) / `SBU_CLK_NS)
`endif

// ---- rtl/sbu_debounce.v ----
// debounce filter for a group of static control pins
`timescale 1ns/100ps
`include "sbu_consts.vh"

module sbu_debounce #(
    parameter W   = 4,
    parameter CYC = `SBU_DEB_CYC
) (
    input  wire         core_clk,
    input  wire         rst_b,
    input  wire         hold,
    input  wire [W-1:0] raw,
    output reg  [W-1:0] stable_r
);

    reg [W-1:0] cand_r;
    reg [7:0]   cnt_r;

    // a level must stand unchanged for the whole count before it is taken
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cand_r   <= {W{1'b0}};
            cnt_r    <= 8'h00;
            stable_r <= {W{1'b0}};
        end else if (hold) begin
            cand_r <= raw;
            cnt_r  <= 8'h00;
        end else if (raw != cand_r) begin
            cand_r <= raw;
            cnt_r  <= 8'h00;
        end else if (cnt_r < CYC[7:0]) begin
            cnt_r <= cnt_r + 8'h01;
        end else begin
            stable_r <= cand_r;
        end
    end

endmodule // sbu_debounce

// ---- rtl/sbu_path_select_decoder.v ----
// control decode for the sbu passive multiplexer
`timescale 1ns/100ps
`include "sbu_consts.vh"

module sbu_path_select_decoder #(
    parameter THREE_WAY = 1'b0,
    parameter BBM_CYC   = `SBU_BBM_CYC
) (
    input  wire       core_clk,
    input  wire       rst_b,
    input  wire       output_enable_n,
    input  wire       strap_is_mid,
    input  wire       strap_is_high,
    input  wire       path_select_bit1,
    input  wire       path_select_bit0,
    input  wire       polarity_swap_pin,
    input  wire [1:0] switch_select_field,
    input  wire       swap_select_field,
    input  wire       chip_enable_bit,
    output reg        reg_mode_r,
    output reg        addr_second_r,
    output reg        bus_active_r,
    output reg        sw_b_straight_r,
    output reg        sw_b_swapped_r,
    output reg        sw_audio_r,
    output reg        sw_c_straight_r,
    output reg        sw_a_straight_r,
    output reg        sw_a_swapped_r,
    output reg        bbm_busy_r
);

    ////////////////////////////////////////////////////////////////////
    // decode helpers

    // map select code plus swap onto one switch; audio and lane c ignore
    // the swap because those paths have no crossed variant
    function [`SBU_SW_W-1:0] sbu_decode;
        input [1:0] path;
        input       swap;
        begin
            sbu_decode = {`SBU_SW_W{1'b0}};
            case (path)
                `SBU_PATH_B: begin
                    if (swap)
                        sbu_decode[`SBU_SW_B_SWP] = 1'b1;
                    else
                        sbu_decode[`SBU_SW_B_STR] = 1'b1;
                end
                `SBU_PATH_AUDIO: begin
                    sbu_decode[`SBU_SW_AUDIO] = 1'b1;
                end
                `SBU_PATH_C: begin
                    sbu_decode[`SBU_SW_C_STR] = 1'b1;
                end
                default: begin
                    if (swap)
                        sbu_decode[`SBU_SW_A_SWP] = 1'b1;
                    else
                        sbu_decode[`SBU_SW_A_STR] = 1'b1;
                end
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // debounce of pins and strap

    wire [4:0] pins_raw;
    wire [4:0] pins_deb;

    assign pins_raw = {strap_is_high, strap_is_mid, path_select_bit1,
                       path_select_bit0, polarity_swap_pin};

    sbu_debounce #(
        .W   (5),
        .CYC (`SBU_DEB_CYC)
    ) u_deb (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .hold     (output_enable_n),
        .raw      (pins_raw),
        .stable_r (pins_deb)
    );

    ////////////////////////////////////////////////////////////////////
    // mode and target selection

    reg  [1:0]          lvl;
    reg  [1:0]          sel_path;
    reg                 sel_swap;
    wire [`SBU_SW_W-1:0] target;
    wire                sw_allowed;

    // high wins when both comparator outputs claim a level
    always @* begin
        if (pins_deb[4])
            lvl = `SBU_LVL_HIGH;
        else if (pins_deb[3])
            lvl = `SBU_LVL_MID;
        else
            lvl = `SBU_LVL_LOW;
    end

    always @* begin
        if (lvl != `SBU_LVL_LOW) begin
            sel_path = switch_select_field;
            sel_swap = swap_select_field;
        end else begin
            sel_path = pins_deb[2:1];
            sel_swap = THREE_WAY ? pins_deb[0] : 1'b0;
        end
    end

    // disabled or reset means every switch open
    assign sw_allowed = !output_enable_n &&
                        (lvl == `SBU_LVL_LOW || chip_enable_bit);
    assign target = sw_allowed ? sbu_decode(sel_path, sel_swap)
                               : {`SBU_SW_W{1'b0}};

    ////////////////////////////////////////////////////////////////////
    // break-before-make sequencer

    localparam ST_IDLE  = 2'h0;
    localparam ST_BREAK = 2'h1;

    reg [1:0]           state_r;
    reg [1:0]           state_nxt;
    reg [`SBU_SW_W-1:0] sw_r;
    reg [`SBU_SW_W-1:0] sw_nxt;
    reg [`SBU_SW_W-1:0] pend_r;
    reg [`SBU_SW_W-1:0] pend_nxt;
    reg [7:0]           gap_r;
    reg [7:0]           gap_nxt;

    // the gap restarts if the target moves again mid-break, so the new
    // path never closes before a full gap with everything open
    always @* begin
        state_nxt = state_r;
        sw_nxt    = sw_r;
        pend_nxt  = pend_r;
        gap_nxt   = gap_r;
        case (state_r)
            ST_IDLE: begin
                if (target != sw_r) begin
                    if (sw_r == {`SBU_SW_W{1'b0}}) begin
                        sw_nxt = target;
                    end else begin
                        sw_nxt    = {`SBU_SW_W{1'b0}};
                        pend_nxt  = target;
                        gap_nxt   = 8'h00;
                        state_nxt = ST_BREAK;
                    end
                end
            end
            ST_BREAK: begin
                if (target != pend_r) begin
                    pend_nxt = target;
                    gap_nxt  = 8'h00;
                end else if (gap_r < BBM_CYC[7:0] - 8'h01) begin
                    gap_nxt = gap_r + 8'h01;
                end else begin
                    sw_nxt    = pend_r;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                sw_nxt    = {`SBU_SW_W{1'b0}};
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            sw_r    <= {`SBU_SW_W{1'b0}};
            pend_r  <= {`SBU_SW_W{1'b0}};
            gap_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            sw_r    <= sw_nxt;
            pend_r  <= pend_nxt;
            gap_r   <= gap_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_mode_r      <= 1'b0;
            addr_second_r   <= 1'b0;
            bus_active_r    <= 1'b0;
            sw_b_straight_r <= 1'b0;
            sw_b_swapped_r  <= 1'b0;
            sw_audio_r      <= 1'b0;
            sw_c_straight_r <= 1'b0;
            sw_a_straight_r <= 1'b0;
            sw_a_swapped_r  <= 1'b0;
            bbm_busy_r      <= 1'b0;
        end else begin
            reg_mode_r      <= (lvl != `SBU_LVL_LOW);
            addr_second_r   <= (lvl == `SBU_LVL_HIGH);
            bus_active_r    <= !output_enable_n &&
                               (lvl != `SBU_LVL_LOW);
            sw_b_straight_r <= sw_nxt[`SBU_SW_B_STR];
            sw_b_swapped_r  <= sw_nxt[`SBU_SW_B_SWP];
            sw_audio_r      <= sw_nxt[`SBU_SW_AUDIO];
            sw_c_straight_r <= sw_nxt[`SBU_SW_C_STR];
            sw_a_straight_r <= sw_nxt[`SBU_SW_A_STR];
            sw_a_swapped_r  <= sw_nxt[`SBU_SW_A_SWP];
            bbm_busy_r      <= (state_nxt == ST_BREAK);
        end
    end

endmodule // sbu_path_select_decoder

// ---- tb/sbu_path_select_decoder_assertions.sv ----
// checker for the sbu path select decoder ports
`timescale 1ns/100ps
module sbu_path_select_decoder_assertions #(
    parameter THREE_WAY = 1'b0,
    parameter BBM_CYC   = 33
) (
    input wire core_clk,
    input wire rst_b,
    input wire output_enable_n,
    input wire chip_enable_bit,
    input wire reg_mode_r,
    input wire addr_second_r,
    input wire bus_active_r,
    input wire sw_b_straight_r,
    input wire sw_b_swapped_r,
    input wire sw_audio_r,
    input wire sw_c_straight_r,
    input wire sw_a_straight_r,
    input wire sw_a_swapped_r,
    input wire bbm_busy_r
);
    wire [5:0] sw = {sw_a_swapped_r, sw_a_straight_r, sw_c_straight_r,
                     sw_audio_r, sw_b_swapped_r, sw_b_straight_r};
    reg  [7:0] gap_r;
    // length of the current all-open gap
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) gap_r <= 8'h00;
        else gap_r <= bbm_busy_r ? gap_r + 8'h01 : 8'h00;
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_gap_start; $rose(bbm_busy_r); endsequence
    sequence s_gap_end; $fell(bbm_busy_r); endsequence
    a_one_path: assert property ($onehot0(sw))
        else $error("more than one switch closed");
    a_oe_open: assert property (output_enable_n |=> sw == 6'h00 && !bus_active_r)
        else $error("switch closed with enable pin high");
    a_break_first: assert property (sw != 6'h00 && $past(sw) != 6'h00 |-> sw == $past(sw))
        else $error("path changed without open gap");
    a_busy_open: assert property (bbm_busy_r |-> sw == 6'h00)
        else $error("switch closed during gap");
    a_gap_len: assert property (s_gap_end |-> gap_r >= BBM_CYC)
        else $error("open gap too short");
    a_gap_bound: assert property (s_gap_start |-> ##[1:1000] !bbm_busy_r)
        else $error("open gap never ends");
    a_addr_mode: assert property (addr_second_r |-> reg_mode_r)
        else $error("second address outside register mode");
    a_bus_mode: assert property (bus_active_r |-> reg_mode_r && !$past(output_enable_n))
        else $error("bus active when it should not be");
    a_pin_noswap: assert property (THREE_WAY == 0 && (sw[5] || sw[1]) |-> reg_mode_r)
        else $error("swap in pin mode on four-way part");
    // reg_mode_r lags the debounced strap by one edge, so test the mode that the
    // decode actually used: the one seen on the following edge
    a_ce_open: assert property (
        !chip_enable_bit ##1 reg_mode_r |-> sw == 6'h00)
        else $error("switch closed with enable bit clear");
endmodule // sbu_path_select_decoder_assertions

bind sbu_path_select_decoder sbu_path_select_decoder_assertions #(
    .THREE_WAY(THREE_WAY), .BBM_CYC(BBM_CYC)) u_chk (
    .core_clk, .rst_b, .output_enable_n, .chip_enable_bit, .reg_mode_r,
    .addr_second_r, .bus_active_r, .sw_b_straight_r, .sw_b_swapped_r,
    .sw_audio_r, .sw_c_straight_r, .sw_a_straight_r, .sw_a_swapped_r,
    .bbm_busy_r);

// ---- tb/sbu_host_model.sv ----
// port controller model driving strap, select pins and mode fields
`timescale 1ns/100ps
module sbu_host_model (
    input  wire       core_clk,
    input  wire [8:0] req,
    output reg  [8:0] ctl_r
);
    initial ctl_r = 9'h000;
    // levels move just after an edge; audio codes keep the swap bit as
    // given, mic/ground order is the codec's business
    always @(posedge core_clk) begin
        ctl_r <= req;
    end
endmodule // sbu_host_model

// ---- tb/sbu_path_select_decoder_tb.sv ----
// self-checking bench for the sbu path select decoder
`timescale 1ns/100ps
module sbu_path_select_decoder_tb;
    localparam BBM = 4;
    reg         core_clk        = 1'b0;
    reg         rst_b           = 1'b0;
    reg         output_enable_n = 1'b0;
    reg  [8:0]  req             = 9'h000;
    wire [8:0]  ctl;
    wire [9:0]  o;
    wire [9:0]  o3;
    reg  [16:0] rows [0:14];
    integer     n_mismatch      = 0;
    integer     total_checks    = 0;
    integer     cyc             = 0;
    integer     i;
    integer     n;
    always #20 core_clk = ~core_clk;
    sbu_host_model u_sbu_host_model (.core_clk(core_clk), .req(req),
        .ctl_r(ctl));
    sbu_path_select_decoder #(.THREE_WAY(1'b0), .BBM_CYC(BBM))
        u_sbu_path_select_decoder (.core_clk(core_clk), .rst_b(rst_b),
        .output_enable_n(output_enable_n), .strap_is_mid(ctl[8]),
        .strap_is_high(ctl[7]), .path_select_bit1(ctl[6]),
        .path_select_bit0(ctl[5]), .polarity_swap_pin(ctl[4]),
        .switch_select_field(ctl[3:2]), .swap_select_field(ctl[1]),
        .chip_enable_bit(ctl[0]), .bus_active_r(o[9]), .reg_mode_r(o[8]),
        .addr_second_r(o[7]), .bbm_busy_r(o[6]), .sw_a_swapped_r(o[5]),
        .sw_a_straight_r(o[4]), .sw_c_straight_r(o[3]), .sw_audio_r(o[2]),
        .sw_b_swapped_r(o[1]), .sw_b_straight_r(o[0]));
    // three-way part on the same pins, the only one that obeys the swap pin
    sbu_path_select_decoder #(.THREE_WAY(1'b1), .BBM_CYC(BBM))
        u_sbu_path_select_decoder_3w (.core_clk(core_clk), .rst_b(rst_b),
        .output_enable_n(output_enable_n), .strap_is_mid(ctl[8]),
        .strap_is_high(ctl[7]), .path_select_bit1(ctl[6]),
        .path_select_bit0(ctl[5]), .polarity_swap_pin(ctl[4]),
        .switch_select_field(ctl[3:2]), .swap_select_field(ctl[1]),
        .chip_enable_bit(ctl[0]), .bus_active_r(o3[9]),
        .reg_mode_r(o3[8]), .addr_second_r(o3[7]), .bbm_busy_r(o3[6]),
        .sw_a_swapped_r(o3[5]), .sw_a_straight_r(o3[4]),
        .sw_c_straight_r(o3[3]), .sw_audio_r(o3[2]),
        .sw_b_swapped_r(o3[1]), .sw_b_straight_r(o3[0]));
    ////////////////////////////////////////////////////////////////////
    task check(input [9:0] seen, input [9:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            if (n_mismatch == 0 && total_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // ceiling well above the roughly 500 cycles the run needs
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // row: {mid, high, path_select_bit1, path_select_bit0, swap pin, field, swap bit, enable bit,
    //       reg mode, second address, switches a_swp..b_str}
    initial begin
        rows[0] = 17'h01001;
        rows[1] = 17'h02004;
        rows[2] = 17'h05008;
        rows[3] = 17'h07010;
        rows[4] = 17'h16181;
        rows[5] = 17'h16382;
        rows[6] = 17'h16584;
        rows[7] = 17'h16784;
        rows[8] = 17'h16988;
        rows[9] = 17'h16b88;
        rows[10] = 17'h16d90;
        rows[11] = 17'h16fa0;
        rows[12] = 17'h0efe0;
        rows[13] = 17'h1efe0;
        rows[14] = 17'h1eec0;
        repeat (10) @(negedge core_clk);
        check(o, 10'h000);
        @(posedge core_clk) rst_b <= 1'b1;
        for (i = 0; i < 15; i = i + 1) begin
            @(posedge core_clk) req <= rows[i][16:8];
            repeat (20) @(negedge core_clk);
            check(o, {rows[i][7], rows[i][7:6], 1'b0, rows[i][5:0]});
        end
        // closed path to another: open gap of exactly BBM cycles
        @(posedge core_clk) req <= 9'h161;
        repeat (20) @(posedge core_clk);
        req <= 9'h165;
        n = 0;
        repeat (40) begin
            @(negedge core_clk);
            if (o[6] === 1'b1) n = n + 1;
        end
        check({6'h00, n[3:0]}, 10'h004);
        check(o, 10'h304);
        // enable pin high opens everything and stops the bus
        @(posedge core_clk) output_enable_n <= 1'b1;
        repeat (3) @(negedge core_clk);
        // disabling runs the same open gap, so busy still stands here
        check({2'b00, o[9], o[6:0]}, 10'h040);
        @(posedge core_clk) output_enable_n <= 1'b0;
        repeat (30) @(negedge core_clk);
        check(o, 10'h304);
        // a three-cycle select glitch is shorter than the debounce
        @(posedge core_clk) req <= 9'h010;
        repeat (30) @(posedge core_clk);
        req <= 9'h070;
        repeat (3) @(posedge core_clk);
        req <= 9'h010;
        repeat (20) begin
            @(negedge core_clk);
            check(o, 10'h001);
            check(o3, 10'h002);
        end
        finish_test;
    end
endmodule // sbu_path_select_decoder_tb
